// ### design/tetm_top.sv
// thermal event pin timer, limit monitor, fan full_speed_on_event and overtemp drive
// Behaviour
// R1 - event monitoring only with enable bit set
// R2 - config bit selects alternate or tach pin
// R3 - after reset monitoring enabled on tach pin
// R4 - full speed bit forces fans 100% while low
// R5 - no full_speed_on_event when fan stopped or cold
// R6 - full speed bit clear keeps current duty
// R7 - timer counts only while input asserted, accumulates
// R8 - timer saturates at full scale, read clears
// R9 - bit0 on first assertion, then 22.76 ms LSB
// R10 - read during assertion restarts with bit0 set
// R11 - limit zero refires flag after such read
// R12 - timer above limit sets flag, requests alert
// R13 - limit spans first assertion to 5.825 s
// R14 - mask bit blocks alert, flag still sets
// R15 - limit 0 first assertion, 1 past 45.52ms
// R16 - config bits route alert to two pins
// R17 - enabled channel at or above limit+0.25 drives pin
// R18 - drive re-evaluated per measurement, released at limit
// R19 - critical limits at 0x6a 0x6b 0x6c
// R20 - bit3 of 0x5f-0x61 enables drive output
// R21 - status flags sticky, clear on read after cause
// R22 - alert held while condition or unread status
// R23 - alert disabled on both pins after reset
// R24 - event input two-stage synchronised
// R25 - prescaled tick, clear and increment never lost
`timescale 1ns/1ps
`default_nettype none

module tetm_top #(
    parameter int TICK_CYCLES = tetm_pkg::TICK_CYCLES,
    parameter int NUM_FANS = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port from the serial bus engine
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // event pin shared with tachometer, open drain
    input wire logic event_tach_pin_in,
    output logic event_tach_pin_out,
    output logic event_tach_pin_oe,
    // alternate event pin, open drain
    input wire logic event_alt_pin_in,
    output logic event_alt_pin_out,
    output logic event_alt_pin_oe,
    // alert candidate pins, open drain, active low
    output logic alert_first_pin_out,
    output logic alert_first_pin_oe,
    output logic alert_second_pin_out,
    output logic alert_second_pin_oe,
    // fan duty path
    input wire logic [NUM_FANS*8-1:0] fan_duty_in,
    input wire logic [NUM_FANS-1:0] fan_auto_mode,
    input wire logic [NUM_FANS-1:0] fan_above_start,
    output logic [NUM_FANS*8-1:0] fan_duty_out,
    // temperature measurements, 2 fraction bits, order remote1 local remote2
    input wire logic [tetm_pkg::NUM_TEMP_CH*10-1:0] temp_meas,
    input wire logic [tetm_pkg::NUM_TEMP_CH-1:0] temp_valid
);

    localparam int NCH = tetm_pkg::NUM_TEMP_CH;
    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);

    logic [7:0] temp_cfg_r [NCH];
    logic [7:0] crit_lim_r [NCH];
    logic [7:0] mask2_r;
    logic [7:0] cfg3_r;
    logic [7:0] cfg4_r;
    logic [7:0] limit_r;
    logic [7:0] ticks_r;
    logic seen_r;
    logic [PW-1:0] presc_r;
    logic [1:0] sync_tach_r;
    logic [1:0] sync_alt_r;
    logic flag_lim_r;
    logic flag_overtemp_r;
    logic [NCH-1:0] hot_r;
    logic drive_r;
    logic alert_r;
    logic [7:0] timer_val;
    logic event_low;
    logic asserted;
    logic tick;
    logic timer_rd;
    logic stat_rd;
    logic lim_cond;
    logic [7:0] temp_addr [NCH];
    logic [7:0] lim_addr [NCH];

    assign temp_addr[0] = tetm_pkg::REMOTE1_TEMP_CONFIG_ADDR;
    assign temp_addr[1] = tetm_pkg::LOCAL_TEMP_CONFIG_ADDR;
    assign temp_addr[2] = tetm_pkg::REMOTE2_TEMP_CONFIG_ADDR;
    assign lim_addr[0] = tetm_pkg::REMOTE1_CRITICAL_LIMIT_ADDR; // [R19]
    assign lim_addr[1] = tetm_pkg::LOCAL_CRITICAL_LIMIT_ADDR; // [R19]
    assign lim_addr[2] = tetm_pkg::REMOTE2_CRITICAL_LIMIT_ADDR; // [R19]

    assign timer_rd = reg_rd && reg_addr == tetm_pkg::ASSERTION_TIME_COUNTER_ADDR;
    assign stat_rd = reg_rd && reg_addr == tetm_pkg::STATUS_SECOND_ADDR;

    // only the second stage of each synchroniser is looked at
    always_ff @(posedge clk) begin
        if (srst) begin
            sync_tach_r <= 2'h3;
            sync_alt_r <= 2'h3;
        end else begin
            sync_tach_r <= {sync_tach_r[0], event_tach_pin_in}; // [R24]
            sync_alt_r <= {sync_alt_r[0], event_alt_pin_in}; // [R24]
        end
    end

    // one pin only, never both
    assign event_low = cfg4_r[tetm_pkg::CFG4_EVENT_PIN_ALTERNATE_SELECT_BIT]
        ? !sync_alt_r[1] : !sync_tach_r[1]; // [R2]
    assign asserted = cfg3_r[tetm_pkg::CFG3_EVENT_ENABLE_BIT] && event_low; // [R1]

    // register writes
    always_ff @(posedge clk) begin
        if (srst) begin
            mask2_r <= tetm_pkg::ALERT_MASK_SECOND_RESET;
            cfg3_r <= tetm_pkg::CONFIG_THIRD_RESET; // [R3] [R23]
            cfg4_r <= tetm_pkg::CONFIG_FOURTH_RESET; // [R3] [R23]
            limit_r <= tetm_pkg::ASSERTION_TIME_LIMIT_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                tetm_pkg::ALERT_MASK_SECOND_ADDR: mask2_r <= reg_wdata;
                tetm_pkg::CONFIG_THIRD_ADDR: cfg3_r <= reg_wdata;
                tetm_pkg::CONFIG_FOURTH_ADDR: cfg4_r <= reg_wdata;
                tetm_pkg::ASSERTION_TIME_LIMIT_ADDR: limit_r <= reg_wdata; // [R13]
                default: ;
            endcase
        end
    end

    genvar gc;
    generate
        for (gc = 0; gc < NCH; gc++) begin : g_ch
            logic [9:0] meas;
            logic [9:0] trip;
            logic [9:0] lim_q;
            assign meas = temp_meas[gc*10 +: 10];
            assign lim_q = {crit_lim_r[gc], 2'h0};
            assign trip = lim_q + 10'h001;

            always_ff @(posedge clk) begin
                if (srst) begin
                    temp_cfg_r[gc] <= tetm_pkg::TEMP_CONFIG_RESET;
                    crit_lim_r[gc] <= tetm_pkg::CRITICAL_LIMIT_RESET;
                end else if (reg_wr) begin
                    if (reg_addr == temp_addr[gc]) begin
                        temp_cfg_r[gc] <= reg_wdata; // [R20]
                    end
                    if (reg_addr == lim_addr[gc]) begin
                        crit_lim_r[gc] <= reg_wdata; // [R19]
                    end
                end
            end

            // held between measurements, so low for a full cycle at least
            always_ff @(posedge clk) begin
                if (srst) begin
                    hot_r[gc] <= 1'b0;
                end else if (!temp_cfg_r[gc][tetm_pkg::TEMP_CFG_EVENT_OUT_BIT]) begin
                    hot_r[gc] <= 1'b0; // [R20]
                end else if (temp_valid[gc]) begin
                    if (meas >= trip) begin
                        hot_r[gc] <= 1'b1; // [R17] [R18]
                    end else if (meas <= lim_q) begin
                        hot_r[gc] <= 1'b0; // [R18]
                    end
                end
            end
        end
    endgenerate

    // prescaler runs only while asserted; restarts on a clearing read
    assign tick = asserted && presc_r == TICK_LAST;

    always_ff @(posedge clk) begin
        if (srst || timer_rd || !asserted) begin
            presc_r <= '0;
        end else if (tick) begin
            presc_r <= '0; // [R25]
        end else begin
            presc_r <= presc_r + PW'(1); // [R7]
        end
    end

    // a tick in the clearing cycle still counts from zero
    always_ff @(posedge clk) begin
        if (srst) begin
            ticks_r <= 8'h00;
            seen_r <= 1'b0;
        end else if (timer_rd) begin
            ticks_r <= tick ? 8'h01 : 8'h00; // [R8] [R25]
            seen_r <= asserted; // [R10]
        end else begin
            if (asserted) begin
                seen_r <= 1'b1; // [R9]
            end
            if (tick && ticks_r != tetm_pkg::COUNT_FULL_SCALE) begin
                ticks_r <= ticks_r + 8'h01; // [R7] [R8]
            end
        end
    end

    // below two ticks only the first-assertion bit shows
    assign timer_val = (ticks_r >= 8'h02) ? ticks_r : {7'h00, seen_r}; // [R9]
    assign lim_cond = timer_val > limit_r; // [R12] [R15] [R11]

    // sticky flags: setting wins over a clearing read
    always_ff @(posedge clk) begin
        if (srst) begin
            flag_lim_r <= 1'b0;
            flag_overtemp_r <= 1'b0;
        end else begin
            if (lim_cond) begin
                flag_lim_r <= 1'b1; // [R12] [R14]
            end else if (stat_rd) begin
                flag_lim_r <= 1'b0; // [R21]
            end
            if (|hot_r) begin
                flag_overtemp_r <= 1'b1;
            end else if (stat_rd) begin
                flag_overtemp_r <= 1'b0; // [R21]
            end
        end
    end

    // alert and event drive outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            alert_r <= 1'b0;
            drive_r <= 1'b0;
        end else begin
            alert_r <= (flag_lim_r && !mask2_r[tetm_pkg::STAT2_EVENT_LIMIT_BIT])
                || (flag_overtemp_r
                && !mask2_r[tetm_pkg::STAT2_OVERTEMP_BIT]); // [R22] [R14]
            drive_r <= |hot_r; // [R17]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            alert_first_pin_oe <= 1'b0; // [R23]
            alert_second_pin_oe <= 1'b0; // [R23]
            event_tach_pin_oe <= 1'b0;
            event_alt_pin_oe <= 1'b0;
        end else begin
            alert_first_pin_oe <= alert_r && cfg3_r[tetm_pkg::CFG3_ALERT_BIT]; // [R16]
            alert_second_pin_oe <= alert_r
                && cfg4_r[tetm_pkg::CFG4_ALERT_ON_SECOND_PIN_BIT]; // [R16]
            event_tach_pin_oe <= drive_r
                && !cfg4_r[tetm_pkg::CFG4_EVENT_PIN_ALTERNATE_SELECT_BIT]; // [R2]
            event_alt_pin_oe <= drive_r
                && cfg4_r[tetm_pkg::CFG4_EVENT_PIN_ALTERNATE_SELECT_BIT]; // [R2]
        end
    end

    // open drain pins only ever pull low
    always_ff @(posedge clk) begin
        alert_first_pin_out <= 1'b0;
        alert_second_pin_out <= 1'b0;
        event_tach_pin_out <= 1'b0;
        event_alt_pin_out <= 1'b0;
    end

    genvar gf;
    generate
        for (gf = 0; gf < NUM_FANS; gf++) begin : g_fan
            logic [7:0] duty;
            logic running;
            assign duty = fan_duty_in[gf*8 +: 8];
            // a stopped or cold fan is not kicked on
            assign running = fan_auto_mode[gf] ? fan_above_start[gf]
                : duty != tetm_pkg::DUTY_ZERO; // [R5]
            always_ff @(posedge clk) begin
                if (srst) begin
                    fan_duty_out[gf*8 +: 8] <= tetm_pkg::DUTY_ZERO;
                end else if (cfg3_r[tetm_pkg::CFG3_FULL_SPEED_BIT]
                        && asserted && running) begin
                    fan_duty_out[gf*8 +: 8] <= tetm_pkg::DUTY_FULL; // [R4]
                end else begin
                    fan_duty_out[gf*8 +: 8] <= duty; // [R6]
                end
            end
        end
    endgenerate

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    tetm_pkg::REMOTE1_TEMP_CONFIG_ADDR: reg_rdata <= temp_cfg_r[0];
                    tetm_pkg::LOCAL_TEMP_CONFIG_ADDR: reg_rdata <= temp_cfg_r[1];
                    tetm_pkg::REMOTE2_TEMP_CONFIG_ADDR: reg_rdata <= temp_cfg_r[2];
                    tetm_pkg::REMOTE1_CRITICAL_LIMIT_ADDR: reg_rdata <= crit_lim_r[0];
                    tetm_pkg::LOCAL_CRITICAL_LIMIT_ADDR: reg_rdata <= crit_lim_r[1];
                    tetm_pkg::REMOTE2_CRITICAL_LIMIT_ADDR: reg_rdata <= crit_lim_r[2];
                    tetm_pkg::ALERT_MASK_SECOND_ADDR: reg_rdata <= mask2_r;
                    tetm_pkg::CONFIG_THIRD_ADDR: reg_rdata <= cfg3_r;
                    tetm_pkg::CONFIG_FOURTH_ADDR: reg_rdata <= cfg4_r;
                    tetm_pkg::ASSERTION_TIME_COUNTER_ADDR: reg_rdata <= timer_val;
                    tetm_pkg::ASSERTION_TIME_LIMIT_ADDR: reg_rdata <= limit_r;
                    tetm_pkg::STATUS_SECOND_ADDR: reg_rdata <=
                        {2'h0, flag_lim_r, 3'h0, flag_overtemp_r, 1'b0};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_idle_pause: assert property (!asserted && !timer_rd |=> $stable(ticks_r)) // [R7]
        else $error("timer moved while input idle");
    chk_count_saturates: assert property (
        ticks_r == 8'hff && !timer_rd |=> ticks_r == 8'hff) // [R8]
        else $error("timer left full scale");
    chk_read_clears: assert property (timer_rd && !tick |=> ticks_r == 8'h00) // [R8]
        else $error("timer not cleared on read");
    chk_read_reasserts: assert property (
        timer_rd && asserted |=> timer_val == 8'h01) // [R10]
        else $error("bit0 not set after read during assertion");
    chk_first_bit: assert property (
        $rose(asserted) && ticks_r == 8'h00 |=> timer_val == 8'h01) // [R9]
        else $error("first assertion not shown");
    chk_limit_flag: assert property (lim_cond |=> flag_lim_r) // [R12]
        else $error("limit flag not set");
    chk_flag_sticky: assert property (flag_lim_r && !stat_rd |=> flag_lim_r) // [R21]
        else $error("limit flag dropped without read");
    chk_mask_blocks: assert property (
        mask2_r[5] && mask2_r[1] |=> !alert_r) // [R14]
        else $error("masked alert raised");
    chk_alert_route: assert property (
        alert_r && cfg3_r[0] |=> alert_first_pin_oe) // [R16]
        else $error("alert not on first pin");
    chk_full_speed: assert property (
        cfg3_r[2] && asserted && !fan_auto_mode[0] && fan_duty_in[7:0] != 8'h00
        |=> fan_duty_out[7:0] == 8'hff) // [R4]
        else $error("fan not forced to full");
    chk_no_full_speed_on_event: assert property (
        !cfg3_r[2] |=> fan_duty_out == $past(fan_duty_in)) // [R6]
        else $error("fan changed without full speed bit");
    chk_hold_drive: assert property (temp_valid == '0 && $stable(temp_cfg_r[0])
        && $stable(temp_cfg_r[1]) && $stable(temp_cfg_r[2])
        |=> $stable(hot_r)) // [R18]
        else $error("drive changed between measurements");
    chk_drive_pin: assert property (|hot_r |-> ##2 (event_tach_pin_oe
        || event_alt_pin_oe || $changed(cfg4_r) || !(|$past(hot_r, 2)))) // [R17]
        else $error("event pin not driven");

    cov_limit_hit: cover property ($rose(flag_lim_r));
    cov_read_active: cover property (timer_rd && asserted);
    cov_full_speed_on_event: cover property ($rose(fan_duty_out[7:0] == 8'hff));
    cov_drive: cover property ($rose(drive_r));

endmodule

`default_nettype wire

// ### dv/test_thermal_event_timer_monitor.sv
// register-level bench for the thermal event timer and monitor
`timescale 1ns/1ps
`default_nettype none

module test_thermal_event_timer_monitor;
    logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [23:0] fan_duty_in = 24'h30_00_40;
    logic [2:0] fan_auto = 3'b100, fan_above = 3'b000, temp_valid = 3'b000;
    logic [29:0] temp_meas = 30'h0;
    logic req_t = 1'b0, req_a = 1'b0;
    wire logic [7:0] reg_rdata;
    wire logic [23:0] fan_duty_out;
    wire logic reg_rvalid, t_oe, a_oe, al1_oe, al2_oe, pull_t, pull_a;
    wire logic [3:0] pin_out;
    wire logic tach_pin = ~(pull_t | t_oe);
    wire logic alt_pin = ~(pull_a | a_oe);
    int mismatches = 0, samples_checked = 0, cycles = 0;
    logic [7:0] d;

    always #50 clk = ~clk;

    tetm_top #(.TICK_CYCLES(8), .NUM_FANS(3)) u_dut (
        .clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .event_tach_pin_in(tach_pin),
        .event_tach_pin_out(pin_out[0]), .event_tach_pin_oe(t_oe),
        .event_alt_pin_in(alt_pin), .event_alt_pin_out(pin_out[1]),
        .event_alt_pin_oe(a_oe), .alert_first_pin_out(pin_out[2]),
        .alert_first_pin_oe(al1_oe), .alert_second_pin_out(pin_out[3]),
        .alert_second_pin_oe(al2_oe), .fan_duty_in(fan_duty_in),
        .fan_auto_mode(fan_auto), .fan_above_start(fan_above),
        .fan_duty_out(fan_duty_out), .temp_meas(temp_meas),
        .temp_valid(temp_valid));
    tetm_event_source u_src_t (.clk(clk), .srst(srst), .hold_low(req_t),
        .lag_cycles(4'h0), .pull_low(pull_t));
    tetm_event_source u_src_a (.clk(clk), .srst(srst), .hold_low(req_a),
        .lag_cycles(4'h3), .pull_low(pull_a));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    // every task starts and ends 10 ns after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        int n;
        n = 0;
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            cyc(1);
            n++;
        end
        chk("read valid", 8'h01, {7'h0, reg_rvalid});
        v = reg_rdata;
        // an idle edge keeps a following strobe a separate pulse
        cyc(1);
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask

    // hold the event line low for n cycles, then let the line settle
    task automatic hold(input int n, input bit alt);
        if (alt) req_a = 1'b1;
        else req_t = 1'b1;
        cyc(n);
        req_t = 1'b0;
        req_a = 1'b0;
        cyc(6);
    endtask

    // read-clear the timer, then the status twice so the flags drop
    task automatic flush();
        rd(8'h79, d);
        rd(8'h42, d);
        rd(8'h42, d);
    endtask

    task automatic meas(input int ch, input logic [9:0] m);
        temp_meas[ch*10 +: 10] = m;
        temp_valid[ch] = 1'b1;
        cyc(1);
        temp_valid = 3'b000;
        cyc(4);
    endtask

    initial begin
        cyc(20);
        srst = 1'b0;
        cyc(1);
        chk_rd(8'h78, 8'h02);
        chk_rd(8'h7d, 8'h00);
        chk_rd(8'h7a, 8'h00);
        chk_rd(8'h75, 8'h00);
        chk_rd(8'h6b, 8'h64);
        chk_rd(8'h60, 8'h00);
        chk_rd(8'h79, 8'h00);
        chk_rd(8'h33, 8'h00);
        chk("alert oe", 8'h00, {6'h0, al2_oe, al1_oe});
        $display("test reset done");

        hold(12, 0);
        chk_rd(8'h79, 8'h01);
        hold(100, 0);
        hold(100, 0);
        chk_rd(8'h79, 8'd24);
        hold(2100, 0);
        chk_rd(8'h79, 8'hff);
        chk_rd(8'h79, 8'h00);
        $display("test timer done");

        wr(8'h78, 8'h03);
        wr(8'h7d, 8'h01);
        wr(8'h7a, 8'h01);
        flush();
        hold(12, 0);
        chk("alert oe", 8'h00, {6'h0, al2_oe, al1_oe});
        rd(8'h79, d);
        hold(20, 0);
        chk("alert oe", 8'h03, {6'h0, al2_oe, al1_oe});
        chk_rd(8'h79, 8'h02);
        cyc(4);
        chk("alert oe", 8'h03, {6'h0, al2_oe, al1_oe});
        chk_rd(8'h42, 8'h20);
        cyc(4);
        chk("alert oe", 8'h00, {6'h0, al2_oe, al1_oe});
        chk_rd(8'h42, 8'h00);
        wr(8'h75, 8'h22);
        hold(20, 0);
        chk("alert oe", 8'h00, {6'h0, al2_oe, al1_oe});
        chk_rd(8'h42, 8'h20);
        flush();
        wr(8'h75, 8'h00);
        wr(8'h7a, 8'h00);
        $display("test limit done");

        req_t = 1'b1;
        cyc(30);
        chk_rd(8'h79, 8'h03);
        cyc(3);
        chk_rd(8'h79, 8'h01);
        // first read would drop the flag if the cause had gone
        chk_rd(8'h42, 8'h20);
        chk_rd(8'h42, 8'h20);
        req_t = 1'b0;
        cyc(6);
        flush();
        $display("test read while asserted done");

        wr(8'h78, 8'h00);
        hold(100, 0);
        chk_rd(8'h79, 8'h00);
        wr(8'h78, 8'h02);
        wr(8'h7d, 8'h02);
        hold(100, 0);
        chk_rd(8'h79, 8'h00);
        hold(100, 1);
        chk_rd(8'h79, 8'd12);
        wr(8'h7d, 8'h00);
        $display("test pin select done");

        for (int b = 0; b < 4; b++) begin
            wr(8'h78, b[1] ? 8'h06 : 8'h02);
            fan_above = {b[0], 2'b00};
            req_t = 1'b1;
            cyc(6);
            chk("fan0", b[1] ? 8'hff : 8'h40, fan_duty_out[7:0]);
            chk("fan1", 8'h00, fan_duty_out[15:8]);
            chk("fan2", b == 3 ? 8'hff : 8'h30, fan_duty_out[23:16]);
            req_t = 1'b0;
            cyc(6);
        end
        wr(8'h78, 8'h02);
        $display("test full_speed_on_event done");

        for (int ch = 0; ch < 3; ch++) begin
            logic [7:0] drv;
            // last channel drives the alternate pin instead
            drv = ch == 2 ? 8'h02 : 8'h01;
            wr(8'h7d, ch == 2 ? 8'h02 : 8'h00);
            wr(8'h5f + 8'(ch), 8'h08);
            wr(8'h6a + 8'(ch), 8'h50);
            meas(ch, 10'd320);
            chk("drive oe", 8'h00, {6'h0, a_oe, t_oe});
            meas(ch, 10'd321);
            chk("drive oe", drv, {6'h0, a_oe, t_oe});
            chk("pin out", 8'h00, {4'h0, pin_out});
            temp_meas[ch*10 +: 10] = 10'd0;
            cyc(4);
            chk("drive oe", drv, {6'h0, a_oe, t_oe});
            chk_rd(8'h42, 8'h22);
            meas(ch, 10'd320);
            chk("drive oe", 8'h00, {6'h0, a_oe, t_oe});
            wr(8'h5f + 8'(ch), 8'h00);
        end
        $display("test overtemp drive done");
        stop_test();
    end
endmodule

`default_nettype wire

// ### dv/tetm_event_source.sv
// open-drain event source standing in for a hot output or trip sensor
`timescale 1ns/1ps
`default_nettype none

module tetm_event_source (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // bench request, honoured after lag_cycles so slow sources are covered
    input wire logic hold_low,
    input wire logic [3:0] lag_cycles,
    // open drain: high means the line is pulled low, else pull-up wins
    output logic pull_low
);
    logic [3:0] lag_r;

    always_ff @(posedge clk) begin
        if (srst || !hold_low) begin
            lag_r <= 4'h0;
            pull_low <= 1'b0;
        end else if (lag_r < lag_cycles) begin
            lag_r <= lag_r + 4'h1;
        end else begin
            pull_low <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// ### include/tetm_pkg.sv
// constants for the thermal event timer and monitor block
`default_nettype none
package tetm_pkg;
    // register offsets
    localparam logic [7:0] REMOTE1_TEMP_CONFIG_ADDR = 8'h5f;
    localparam logic [7:0] LOCAL_TEMP_CONFIG_ADDR = 8'h60;
    localparam logic [7:0] REMOTE2_TEMP_CONFIG_ADDR = 8'h61;
    localparam logic [7:0] REMOTE1_CRITICAL_LIMIT_ADDR = 8'h6a;
    localparam logic [7:0] LOCAL_CRITICAL_LIMIT_ADDR = 8'h6b;
    localparam logic [7:0] REMOTE2_CRITICAL_LIMIT_ADDR = 8'h6c;
    localparam logic [7:0] ALERT_MASK_SECOND_ADDR = 8'h75;
    localparam logic [7:0] CONFIG_THIRD_ADDR = 8'h78;
    localparam logic [7:0] ASSERTION_TIME_COUNTER_ADDR = 8'h79;
    localparam logic [7:0] ASSERTION_TIME_LIMIT_ADDR = 8'h7a;
    localparam logic [7:0] CONFIG_FOURTH_ADDR = 8'h7d;
    localparam logic [7:0] STATUS_SECOND_ADDR = 8'h42;

    // field positions
    localparam int CFG3_ALERT_BIT = 0;
    localparam int CFG3_EVENT_ENABLE_BIT = 1;
    localparam int CFG3_FULL_SPEED_BIT = 2;
    localparam int CFG4_ALERT_ON_SECOND_PIN_BIT = 0;
    localparam int CFG4_EVENT_PIN_ALTERNATE_SELECT_BIT = 1;
    localparam int TEMP_CFG_EVENT_OUT_BIT = 3;
    localparam int STAT2_EVENT_LIMIT_BIT = 5;
    localparam int STAT2_OVERTEMP_BIT = 1;

    // values after reset, fan duty levels and counter full scale
    localparam logic [7:0] CONFIG_THIRD_RESET = 8'h02;
    localparam logic [7:0] CONFIG_FOURTH_RESET = 8'h00;
    localparam logic [7:0] ALERT_MASK_SECOND_RESET = 8'h00;
    localparam logic [7:0] TEMP_CONFIG_RESET = 8'h00;
    localparam logic [7:0] CRITICAL_LIMIT_RESET = 8'h64;
    localparam logic [7:0] ASSERTION_TIME_LIMIT_RESET = 8'h00;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [7:0] DUTY_ZERO = 8'h00;
    localparam logic [7:0] COUNT_FULL_SCALE = 8'hff;

    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_US = 22_760;
    localparam int TICK_CYCLES = TICK_US * (CLK_HZ / 1_000_000);

    // number of temperature channels: remote 1, local, remote 2
    localparam int NUM_TEMP_CH = 3;
endpackage
`default_nettype wire
